// *** pkg/cmrm_map.svh ***
// register addresses, field positions, reset values and timing figures of the monitor
`ifndef CMRM_MAP_SVH
`define CMRM_MAP_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CMRM_HIT_CNT_ADDR 32'h1a1c0028
`define CMRM_MISS_CNT_ADDR 32'h1a1c002c
`define CMRM_CTRL_ADDR 32'h1a1c0030
`define CMRM_INTERVAL_ADDR 32'h1a1c0034
`define CMRM_MISS_THR_ADDR 32'h1a1c0038
`define CMRM_HIT_THR_ADDR 32'h1a1c003c
`define CMRM_IRQ_STATUS_ADDR 32'h1a1c0050
`define CMRM_IRQ_MASK_ADDR 32'h1a1c0054

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CMRM_CTRL_RUN_BIT 0
`define CMRM_CTRL_IRQ_EN_BIT 1
`define CMRM_CTRL_INT_END_BIT 2
`define CMRM_CTRL_MISS_THR_BIT 3
`define CMRM_CTRL_HIT_THR_BIT 4
`define CMRM_CTRL_WIDTH 5

// ----------------------------------------
// irq status and mask fields
// ----------------------------------------
`define CMRM_IRQ_INT_END_BIT 0
`define CMRM_IRQ_MISS_THR_BIT 1
`define CMRM_IRQ_HIT_THR_BIT 2
`define CMRM_IRQ_WIDTH 3

// ----------------------------------------
// widths, resets and timing
// ----------------------------------------
`define CMRM_INTERVAL_WIDTH 19
`define CMRM_RESET_VALUE 32'h00000000
`define CMRM_CLK_FREQ_MHZ 100
`define CMRM_REF_FREQ_MHZ 32

`endif

// *** pkg/cmrm_pkg.sv ***
// types shared by the cache miss rate monitor
package cmrm_pkg;

    typedef logic [31:0] cmrm_word_t;

    typedef enum logic [3:0] {
        CMRM_SEL_NONE,
        CMRM_SEL_HIT_CNT,
        CMRM_SEL_MISS_CNT,
        CMRM_SEL_CTRL,
        CMRM_SEL_INTERVAL,
        CMRM_SEL_MISS_THR,
        CMRM_SEL_HIT_THR,
        CMRM_SEL_IRQ_STATUS,
        CMRM_SEL_IRQ_MASK
    } cmrm_sel_t;

endpackage : cmrm_pkg

// *** design/cmrm_top.sv ***
// cache miss rate monitor with ahb-lite register slave
`timescale 1ns/10ps
`include "cmrm_map.svh"


module cmrm_top #(
    parameter int CLK_FREQ_MHZ = `CMRM_CLK_FREQ_MHZ,
    parameter int REF_FREQ_MHZ = `CMRM_REF_FREQ_MHZ,
    parameter int INTERVAL_WIDTH = `CMRM_INTERVAL_WIDTH
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic cache_hit_i,
    input wire logic cache_miss_i,
    output logic irq_pulse_o,
    output logic irq_o
);

    // ----------------------------------------
    // local constants
    // ----------------------------------------
    localparam int ACC_W = $clog2(CLK_FREQ_MHZ + REF_FREQ_MHZ) + 1;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_FREQ_MHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_FREQ_MHZ);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    cmrm_pkg::cmrm_word_t hit_count;
    cmrm_pkg::cmrm_word_t miss_count;
    cmrm_pkg::cmrm_word_t miss_threshold;
    cmrm_pkg::cmrm_word_t hit_threshold;
    logic [INTERVAL_WIDTH-1:0] interval_length;
    logic [INTERVAL_WIDTH-1:0] interval_count;
    logic monitor_run;
    logic monitor_irq_enable;
    logic interval_end_flag;
    logic miss_threshold_flag;
    logic hit_threshold_flag;
    logic [`CMRM_IRQ_WIDTH-1:0] irq_status;
    logic [`CMRM_IRQ_WIDTH-1:0] irq_mask;

    // ----------------------------------------
    // bus phase tracking
    // ----------------------------------------
    cmrm_pkg::cmrm_sel_t addr_sel;
    cmrm_pkg::cmrm_sel_t wr_sel;
    logic wr_pend;
    logic rd_pend;
    cmrm_pkg::cmrm_sel_t rd_sel;
    logic bus_take;
    logic wr_now;
    cmrm_pkg::cmrm_word_t rd_mux;

    // ----------------------------------------
    // events
    // ----------------------------------------
    logic [ACC_W-1:0] ref_acc;
    logic ref_tick;
    logic hit_inc;
    logic miss_inc;
    logic hit_reach;
    logic miss_reach;
    logic interval_end;
    logic [`CMRM_IRQ_WIDTH-1:0] event_vec;
    cmrm_pkg::cmrm_word_t next_hit_count;
    cmrm_pkg::cmrm_word_t next_miss_count;
    logic ctrl_wr;
    logic irq_want;
    logic irq_pend;

    function automatic cmrm_pkg::cmrm_sel_t decode(input logic [31:0] addr);
        unique case (addr)
            `CMRM_HIT_CNT_ADDR: decode = cmrm_pkg::CMRM_SEL_HIT_CNT;
            `CMRM_MISS_CNT_ADDR: decode = cmrm_pkg::CMRM_SEL_MISS_CNT;
            `CMRM_CTRL_ADDR: decode = cmrm_pkg::CMRM_SEL_CTRL;
            `CMRM_INTERVAL_ADDR: decode = cmrm_pkg::CMRM_SEL_INTERVAL;
            `CMRM_MISS_THR_ADDR: decode = cmrm_pkg::CMRM_SEL_MISS_THR;
            `CMRM_HIT_THR_ADDR: decode = cmrm_pkg::CMRM_SEL_HIT_THR;
            `CMRM_IRQ_STATUS_ADDR: decode = cmrm_pkg::CMRM_SEL_IRQ_STATUS;
            `CMRM_IRQ_MASK_ADDR: decode = cmrm_pkg::CMRM_SEL_IRQ_MASK;
            default: decode = cmrm_pkg::CMRM_SEL_NONE;
        endcase
    endfunction : decode

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    assign addr_sel = decode(haddr_i);
    assign bus_take = hsel_i && htrans_i[1] && hready_i;
    assign wr_now = wr_pend;
    assign ctrl_wr = wr_now && (wr_sel == cmrm_pkg::CMRM_SEL_CTRL);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_pend <= 1'b0;
            wr_sel <= cmrm_pkg::CMRM_SEL_NONE;
        end else if (hready_i) begin
            wr_pend <= bus_take && hwrite_i;
            wr_sel <= addr_sel;
        end
    end

    // reads take one wait state so a write just before is visible
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rd_pend <= 1'b0;
            rd_sel <= cmrm_pkg::CMRM_SEL_NONE;
            hreadyout_o <= 1'b1;
            hrdata_o <= `CMRM_RESET_VALUE;
        end else if (rd_pend) begin
            rd_pend <= 1'b0;
            hreadyout_o <= 1'b1;
            hrdata_o <= rd_mux;
        end else if (bus_take && !hwrite_i) begin
            rd_pend <= 1'b1;
            rd_sel <= addr_sel;
            hreadyout_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hresp_o <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = '0;
        unique case (rd_sel)
            cmrm_pkg::CMRM_SEL_HIT_CNT: rd_mux = hit_count;
            cmrm_pkg::CMRM_SEL_MISS_CNT: rd_mux = miss_count;
            cmrm_pkg::CMRM_SEL_CTRL: begin
                rd_mux[`CMRM_CTRL_RUN_BIT] = monitor_run;
                rd_mux[`CMRM_CTRL_IRQ_EN_BIT] = monitor_irq_enable;
                rd_mux[`CMRM_CTRL_INT_END_BIT] = interval_end_flag;
                rd_mux[`CMRM_CTRL_MISS_THR_BIT] = miss_threshold_flag;
                rd_mux[`CMRM_CTRL_HIT_THR_BIT] = hit_threshold_flag;
            end
            cmrm_pkg::CMRM_SEL_INTERVAL: rd_mux[INTERVAL_WIDTH-1:0] = interval_length;
            cmrm_pkg::CMRM_SEL_MISS_THR: rd_mux = miss_threshold;
            cmrm_pkg::CMRM_SEL_HIT_THR: rd_mux = hit_threshold;
            cmrm_pkg::CMRM_SEL_IRQ_STATUS: rd_mux[`CMRM_IRQ_WIDTH-1:0] = irq_status;
            cmrm_pkg::CMRM_SEL_IRQ_MASK: rd_mux[`CMRM_IRQ_WIDTH-1:0] = irq_mask;
            cmrm_pkg::CMRM_SEL_NONE: rd_mux = '0;
            default: rd_mux = '0;
        endcase
    end

    // ----------------------------------------
    // 32 MHz reference tick from fractional divider
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ref_acc <= '0;
            ref_tick <= 1'b0;
        end else if (!monitor_run) begin
            // phase restarts while stopped, so an interval is exactly its length
            ref_acc <= '0;
            ref_tick <= 1'b0;
        end else if (ref_acc + ACC_STEP >= ACC_WRAP) begin
            ref_acc <= ref_acc + ACC_STEP - ACC_WRAP;
            ref_tick <= 1'b1;
        end else begin
            ref_acc <= ref_acc + ACC_STEP;
            ref_tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // event detection
    // ----------------------------------------
    assign hit_inc = monitor_run && cache_hit_i;
    assign miss_inc = monitor_run && cache_miss_i;
    assign next_hit_count = hit_count + 32'h00000001;
    assign next_miss_count = miss_count + 32'h00000001;
    assign hit_reach = hit_inc && (hit_threshold != '0) && (next_hit_count == hit_threshold);
    assign miss_reach = miss_inc && (miss_threshold != '0)
        && (next_miss_count == miss_threshold);
    assign interval_end = monitor_run && ref_tick && (interval_length != '0)
        && (interval_count == INTERVAL_WIDTH'(1));

    always_comb begin
        event_vec = '0;
        event_vec[`CMRM_IRQ_INT_END_BIT] = interval_end;
        event_vec[`CMRM_IRQ_MISS_THR_BIT] = miss_reach;
        event_vec[`CMRM_IRQ_HIT_THR_BIT] = hit_reach;
    end

    // ----------------------------------------
    // hit and miss counters
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hit_count <= `CMRM_RESET_VALUE;
        end else if (wr_now && wr_sel == cmrm_pkg::CMRM_SEL_HIT_CNT) begin
            hit_count <= hwdata_i;
        end else if (hit_inc) begin
            hit_count <= next_hit_count;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            miss_count <= `CMRM_RESET_VALUE;
        end else if (wr_now && wr_sel == cmrm_pkg::CMRM_SEL_MISS_CNT) begin
            miss_count <= hwdata_i;
        end else if (miss_inc) begin
            miss_count <= next_miss_count;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            interval_length <= '0;
            miss_threshold <= `CMRM_RESET_VALUE;
            hit_threshold <= `CMRM_RESET_VALUE;
            irq_mask <= '0;
        end else if (wr_now) begin
            unique case (wr_sel)
                cmrm_pkg::CMRM_SEL_INTERVAL: interval_length <= hwdata_i[INTERVAL_WIDTH-1:0];
                cmrm_pkg::CMRM_SEL_MISS_THR: miss_threshold <= hwdata_i;
                cmrm_pkg::CMRM_SEL_HIT_THR: hit_threshold <= hwdata_i;
                cmrm_pkg::CMRM_SEL_IRQ_MASK: irq_mask <= hwdata_i[`CMRM_IRQ_WIDTH-1:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // control: run and enable
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            monitor_run <= 1'b0;
        end else if (interval_end) begin
            monitor_run <= 1'b0;
        end else if (ctrl_wr) begin
            monitor_run <= hwdata_i[`CMRM_CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            monitor_irq_enable <= 1'b0;
        end else if (ctrl_wr) begin
            monitor_irq_enable <= hwdata_i[`CMRM_CTRL_IRQ_EN_BIT];
        end
    end

    // ----------------------------------------
    // control flags: hardware set wins over software clear
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            interval_end_flag <= 1'b0;
        end else if (interval_end) begin
            interval_end_flag <= 1'b1;
        end else if (ctrl_wr) begin
            interval_end_flag <= hwdata_i[`CMRM_CTRL_INT_END_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            miss_threshold_flag <= 1'b0;
        end else if (miss_reach) begin
            miss_threshold_flag <= 1'b1;
        end else if (ctrl_wr) begin
            miss_threshold_flag <= hwdata_i[`CMRM_CTRL_MISS_THR_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hit_threshold_flag <= 1'b0;
        end else if (hit_reach) begin
            hit_threshold_flag <= 1'b1;
        end else if (ctrl_wr) begin
            hit_threshold_flag <= hwdata_i[`CMRM_CTRL_HIT_THR_BIT];
        end
    end

    // ----------------------------------------
    // interval counter
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            interval_count <= '0;
        end else if (!monitor_run) begin
            interval_count <= interval_length;
        end else if (ref_tick && interval_count != '0) begin
            interval_count <= interval_count - INTERVAL_WIDTH'(1);
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    assign irq_want = monitor_irq_enable && ((|event_vec) || irq_pend);

    // an event right behind a pulse waits one cycle, so pulses never merge
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_pend <= 1'b0;
        end else begin
            irq_pend <= irq_want && irq_pulse_o;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_pulse_o <= 1'b0;
        end else begin
            irq_pulse_o <= irq_want && !irq_pulse_o;
        end
    end

    // ----------------------------------------
    // sticky status, write one to clear, set wins
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_status <= '0;
        end else if (wr_now && wr_sel == cmrm_pkg::CMRM_SEL_IRQ_STATUS) begin
            irq_status <= (irq_status & ~hwdata_i[`CMRM_IRQ_WIDTH-1:0]) | event_vec;
        end else begin
            irq_status <= irq_status | event_vec;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

endmodule : cmrm_top

// *** bench/cmrm_top_monitor.sv ***
// assertion checker bound to the monitor top
`timescale 1ns/10ps
`include "cmrm_map.svh"

module cmrm_top_monitor (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic cache_hit_i,
    input wire logic cache_miss_i,
    input wire logic irq_pulse_o,
    input wire logic irq_o
);
    logic take;
    logic ctrl_wr_q;
    logic mask_wr_q;
    logic run_q;
    logic en_q;
    logic [2:0] mask_q;
    assign take = hsel_i && htrans_i[1] && hready_i;
    // ----------------------------------------
    // shadows of software writes
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl_wr_q <= 1'b0;
            mask_wr_q <= 1'b0;
        end else if (hready_i) begin
            ctrl_wr_q <= take && hwrite_i && haddr_i == `CMRM_CTRL_ADDR;
            mask_wr_q <= take && hwrite_i && haddr_i == `CMRM_IRQ_MASK_ADDR;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
            en_q <= 1'b0;
        end else if (ctrl_wr_q && hready_i) begin
            run_q <= hwdata_i[0];
            en_q <= hwdata_i[1];
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mask_q <= 3'h0;
        end else if (mask_wr_q && hready_i) begin
            mask_q <= hwdata_i[2:0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    property p_pulse_single; irq_pulse_o |=> !irq_pulse_o; endproperty
    property p_irq_gate; irq_pulse_o |-> $past(en_q); endproperty
    property p_idle_no_pulse; irq_pulse_o |-> $past(run_q); endproperty
    property p_irq_mask; irq_o |-> $past(mask_q) != 3'h0; endproperty
    property p_okay; hresp_o == 1'b0; endproperty
    property p_read_wait; take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
    property p_write_nowait; take && hwrite_i |=> hreadyout_o; endproperty
    property p_rdata_hold; hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o); endproperty
    property p_reset_quiet;
        disable iff (1'b0) sys_rst_i |=> !irq_pulse_o && !irq_o && hrdata_o == 32'h0;
    endproperty
    a_pulse_single: assert property (p_pulse_single)
        else $error("irq pulse longer than one cycle");
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq pulse while interrupts disabled");
    a_idle_no_pulse: assert property (p_idle_no_pulse)
        else $error("irq pulse while stopped");
    a_irq_mask: assert property (p_irq_mask)
        else $error("irq level with mask clear");
    a_okay: assert property (p_okay)
        else $error("bus response not okay");
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");
    a_write_nowait: assert property (p_write_nowait)
        else $error("write stalled");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared by reset");
    c_pulse: cover property (irq_pulse_o);
    c_read: cover property (take && !hwrite_i);
    c_irq: cover property (irq_o);
endmodule : cmrm_top_monitor

bind cmrm_top cmrm_top_monitor cmrm_top_monitor_inst (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .cache_hit_i(cache_hit_i), .cache_miss_i(cache_miss_i), .irq_pulse_o(irq_pulse_o),
    .irq_o(irq_o));

// *** bench/cmrm_cache_ctl_model.sv ***
// cache controller model giving hit and miss indications
`timescale 1ns/10ps

module cmrm_cache_ctl_model (
    input wire logic clk_sys_i,
    output logic cache_hit_o,
    output logic cache_miss_o
);
    initial begin
        cache_hit_o = 1'b0;
        cache_miss_o = 1'b0;
    end
    // hits first, then misses, one per cycle, gap idle cycles after each
    task automatic lookups(input int hits, input int misses, input int gap);
        for (int i = 0; i < hits + misses; i++) begin
            cache_hit_o <= (i < hits);
            cache_miss_o <= (i >= hits);
            @(posedge clk_sys_i);
            if (gap > 0) begin
                cache_hit_o <= 1'b0;
                cache_miss_o <= 1'b0;
                repeat (gap) @(posedge clk_sys_i);
            end
        end
        cache_hit_o <= 1'b0;
        cache_miss_o <= 1'b0;
    endtask : lookups
endmodule : cmrm_cache_ctl_model

// *** bench/cache_miss_rate_monitor_tb.sv ***
// self-checking bench for the cache miss rate monitor
`timescale 1ns/10ps
`include "cmrm_map.svh"

module cache_miss_rate_monitor_tb;
    logic clk_sys_i;
    logic sys_rst_i;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hit;
    logic miss;
    logic irq_pulse;
    logic irq;
    int miscompares = 0;
    int check_count = 0;
    int pulses = 0;
    int p0;

    cmrm_top cmrm_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(), .cache_hit_i(hit), .cache_miss_i(miss),
        .irq_pulse_o(irq_pulse), .irq_o(irq));
    cmrm_cache_ctl_model cmrm_cache_ctl_model_inst (.clk_sys_i(clk_sys_i),
        .cache_hit_o(hit), .cache_miss_o(miss));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (irq_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), e, r);
    endtask : rd_chk
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        logic [31:0] a[9] = '{`CMRM_HIT_CNT_ADDR, `CMRM_MISS_CNT_ADDR, `CMRM_CTRL_ADDR,
            `CMRM_INTERVAL_ADDR, `CMRM_MISS_THR_ADDR, `CMRM_HIT_THR_ADDR,
            `CMRM_IRQ_STATUS_ADDR, `CMRM_IRQ_MASK_ADDR, 32'h1a1c0040};
        foreach (a[i]) rd_chk(a[i], 32'h0);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_regs;
        wr(`CMRM_HIT_CNT_ADDR, 32'ha5a51234);
        rd_chk(`CMRM_HIT_CNT_ADDR, 32'ha5a51234);
        wr(`CMRM_INTERVAL_ADDR, 32'hffffffff);
        rd_chk(`CMRM_INTERVAL_ADDR, 32'h0007ffff);
        wr(`CMRM_CTRL_ADDR, 32'hffffffe2);
        rd_chk(`CMRM_CTRL_ADDR, 32'h00000002);
        wr(`CMRM_MISS_THR_ADDR, 32'hfffffffe);
        rd_chk(`CMRM_MISS_THR_ADDR, 32'hfffffffe);
        wr(`CMRM_HIT_THR_ADDR, 32'h80000001);
        rd_chk(`CMRM_HIT_THR_ADDR, 32'h80000001);
        wr(32'h1a1c0040, 32'hffffffff);
        rd_chk(32'h1a1c0040, 32'h0);
        wr(`CMRM_INTERVAL_ADDR, 32'h0);
        wr(`CMRM_MISS_THR_ADDR, 32'h0);
        wr(`CMRM_HIT_THR_ADDR, 32'h0);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_count;
        wr(`CMRM_HIT_CNT_ADDR, 32'h0);
        wr(`CMRM_MISS_CNT_ADDR, 32'hfffffffe);
        wr(`CMRM_IRQ_MASK_ADDR, 32'h7);
        wr(`CMRM_CTRL_ADDR, 32'h3);
        p0 = pulses;
        cmrm_cache_ctl_model_inst.lookups(5, 3, 0);
        cmrm_cache_ctl_model_inst.lookups(2, 1, 2);
        wr(`CMRM_CTRL_ADDR, 32'h2);
        cmrm_cache_ctl_model_inst.lookups(4, 4, 1);
        rd_chk(`CMRM_HIT_CNT_ADDR, 32'h7);
        rd_chk(`CMRM_MISS_CNT_ADDR, 32'h2);
        rd_chk(`CMRM_CTRL_ADDR, 32'h2);
        chk("pulses", 32'h0, 32'(pulses - p0));
        chk("irq", 32'h0, {31'h0, irq});
        $display("test_count done");
    endtask : test_count
    task automatic test_thresh;
        wr(`CMRM_HIT_CNT_ADDR, 32'h0);
        wr(`CMRM_MISS_CNT_ADDR, 32'h0);
        wr(`CMRM_MISS_THR_ADDR, 32'h2);
        wr(`CMRM_HIT_THR_ADDR, 32'h3);
        wr(`CMRM_CTRL_ADDR, 32'h1);
        p0 = pulses;
        cmrm_cache_ctl_model_inst.lookups(3, 2, 1);
        rd_chk(`CMRM_CTRL_ADDR, 32'h19);
        chk("pulses", 32'h0, 32'(pulses - p0));
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk(`CMRM_IRQ_STATUS_ADDR, 32'h6);
        wr(`CMRM_IRQ_STATUS_ADDR, 32'h2);
        rd_chk(`CMRM_IRQ_STATUS_ADDR, 32'h4);
        wr(`CMRM_IRQ_MASK_ADDR, 32'h3);
        rd_chk(`CMRM_IRQ_MASK_ADDR, 32'h3);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`CMRM_IRQ_MASK_ADDR, 32'h7);
        wr(`CMRM_IRQ_STATUS_ADDR, 32'h4);
        rd_chk(`CMRM_IRQ_STATUS_ADDR, 32'h0);
        wr(`CMRM_CTRL_ADDR, 32'h3);
        rd_chk(`CMRM_CTRL_ADDR, 32'h3);
        wr(`CMRM_HIT_CNT_ADDR, 32'h0);
        wr(`CMRM_MISS_CNT_ADDR, 32'h0);
        p0 = pulses;
        cmrm_cache_ctl_model_inst.lookups(3, 2, 0);
        rd_chk(`CMRM_CTRL_ADDR, 32'h1b);
        chk("pulses", 32'h2, 32'(pulses - p0));
        wr(`CMRM_HIT_THR_ADDR, 32'h4);
        wr(`CMRM_MISS_THR_ADDR, 32'h3);
        p0 = pulses;
        cmrm_cache_ctl_model_inst.lookups(1, 1, 0);
        repeat (3) @(posedge clk_sys_i);
        chk("pulses", 32'h2, 32'(pulses - p0));
        wr(`CMRM_CTRL_ADDR, 32'h0);
        rd_chk(`CMRM_CTRL_ADDR, 32'h0);
        $display("test_thresh done");
    endtask : test_thresh
    task automatic test_interval;
        wr(`CMRM_IRQ_STATUS_ADDR, 32'h7);
        wr(`CMRM_INTERVAL_ADDR, 32'ha);
        wr(`CMRM_CTRL_ADDR, 32'h3);
        p0 = pulses;
        repeat (14) @(posedge clk_sys_i);
        rd_chk(`CMRM_CTRL_ADDR, 32'h3);
        repeat (30) @(posedge clk_sys_i);
        rd_chk(`CMRM_CTRL_ADDR, 32'h6);
        chk("pulses", 32'h1, 32'(pulses - p0));
        rd_chk(`CMRM_IRQ_STATUS_ADDR, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        $display("test_interval done");
    endtask : test_interval
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (5) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        test_reset();
        test_regs();
        test_count();
        test_thresh();
        test_interval();
        end_of_test();
    end
    initial begin
        #20us;
        miscompares++;
        end_of_test();
    end
endmodule : cache_miss_rate_monitor_tb
